// file: shared/frsb_regs.svh
`ifndef FRSB_REGS_SVH
`define FRSB_REGS_SVH

// ==========================================================
// register offsets
`define FRSB_OFS_LONGEST_LOW 8'h19
`define FRSB_OFS_LONGEST_HIGH 8'h1A
`define FRSB_OFS_SHORTEST_LOW 8'h1B
`define FRSB_OFS_SHORTEST_HIGH 8'h1C
`define FRSB_OFS_EXPOSURE_LOW 8'h1D
`define FRSB_OFS_EXPOSURE_HIGH 8'h1E
`define FRSB_OFS_FIRMWARE_REV 8'h1F
`define FRSB_OFS_LASER_DRIVE 8'h2C

// ==========================================================
// reset values
`define FRSB_RST_LONGEST_LOW 8'h90
`define FRSB_RST_LONGEST_HIGH 8'h65
`define FRSB_RST_SHORTEST_LOW 8'h7E
`define FRSB_RST_SHORTEST_HIGH 8'h0E
`define FRSB_RST_EXPOSURE_LOW 8'h20
`define FRSB_RST_EXPOSURE_HIGH 8'h4E
`define FRSB_RST_LASER_DRIVE 8'h7F

// ==========================================================
// field positions and constants
`define FRSB_LASER_MATCH_BIT 7
`define FRSB_LASER_CODE_MSB 6
`define FRSB_LASER_CODE_LOWEST 7'h7F
`define FRSB_FIRMWARE_NONE 8'h00
`define FRSB_APPLY_FRAMES 2'h2

// ==========================================================
// timing
`define FRSB_CLK_PERIOD_NS 10
`define FRSB_FAULT_PULSE_NS 12000
`define FRSB_FAULT_PULSE_CYCLES (`FRSB_FAULT_PULSE_NS / `FRSB_CLK_PERIOD_NS)

`endif

// file: shared/frsb_pkg.sv
// ==========================================================
// types shared by the frame bound register bank
package frsb_pkg;

    // staged limit commit progress
    typedef enum logic [1:0] {
        COMMIT_IDLE,
        COMMIT_WAIT_FIRST,
        COMMIT_WAIT_SECOND
    } frsb_commit_type;

    // laser drive pin fault test progress
    typedef enum logic [1:0] {
        FAULT_IDLE,
        FAULT_PULSE_HIGH,
        FAULT_PULSE_LOW
    } frsb_fault_type;

endpackage : frsb_pkg

// file: logic/frsb_frame_timer.sv
`timescale 1ns/1ps
// ==========================================================
// frame period counter, one pulse per frame
module frsb_frame_timer
    import frsb_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // period in clock cycles
    input wire logic [15:0] period_in,
    // frame boundary
    output logic frame_start_out
);

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] last_count;
    logic wrap;

    // a period of zero would wrap only every 65536 cycles, so treat it as one cycle
    assign last_count = (period_in == 16'h0000) ? 16'h0000 : period_in - 16'h0001;
    assign wrap = (count_reg >= last_count);
    assign count_next = wrap ? 16'h0000 : count_reg + 16'h0001;
    assign frame_start_out = wrap;

    // cycle counter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg <= 16'h0000;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : frsb_frame_timer

// file: logic/frsb_bank.sv
`timescale 1ns/1ps
`include "frsb_regs.svh"
// Functional notes
// - longest interval is the auto frame period ceiling and the manual frame period
// - all limits counted in clock cycles; frame rate is clock over period
// - all three limit pairs commit together on longest upper write
// - written limits stay staged without effect until the commit write
// - new limits take effect at the second frame start after commit
// - busy indication exposed so host can poll instead of timing frames
// - shortest interval is the smallest frame period auto control may pick
// - shortest and exposure reads return last written byte, committed or not
// - auto exposure is capped at the exposure ceiling
// - manual exposure: auto gain off, ceiling value used directly
// - firmware revision reads shadow revision while running it, else 0x00
// - laser code used only when complement matches, else lowest current
// - laser drive write runs 12us high then 12us low pin fault test
module frsb_bank
    import frsb_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register access port from the serial port engine
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // auxiliary control bits
    input wire logic auto_frame_rate_en_in,
    input wire logic auto_exposure_en_in,
    output logic busy_out,
    // automatic control requests
    input wire logic [15:0] auto_period_req_in,
    input wire logic [15:0] auto_exposure_req_in,
    // operating values
    output logic [15:0] frame_period_out,
    output logic [15:0] exposure_out,
    output logic frame_start_out,
    // shadow firmware status
    input wire logic shadow_running_in,
    input wire logic [7:0] shadow_revision_in,
    // laser drive
    input wire logic [7:0] laser_drive_complement_in,
    input wire logic laser_drive_normal_in,
    input wire logic laser_enable_low_normal_in,
    output logic [6:0] laser_current_code_out,
    output logic laser_match_out,
    output logic laser_drive_pin_out,
    output logic laser_enable_low_out
);

    // ==========================================================
    // staging storage, written by the host
    logic [7:0] longest_low_reg;
    logic [7:0] longest_high_reg;
    logic [7:0] shortest_low_reg;
    logic [7:0] shortest_high_reg;
    logic [7:0] exposure_low_reg;
    logic [7:0] exposure_high_reg;
    logic [7:0] laser_drive_reg;

    // pending values, captured at the commit write
    logic [15:0] pend_longest_reg;
    logic [15:0] pend_shortest_reg;
    logic [15:0] pend_exposure_reg;

    // active limits that steer the frame and exposure logic
    logic [15:0] act_longest_reg;
    logic [15:0] act_shortest_reg;
    logic [15:0] act_exposure_reg;

    // ==========================================================
    // write decode
    logic wr_longest_low;
    logic wr_longest_high;
    logic wr_shortest_low;
    logic wr_shortest_high;
    logic wr_exposure_low;
    logic wr_exposure_high;
    logic wr_laser_drive;

    assign wr_longest_low = reg_write_in && (reg_addr_in == `FRSB_OFS_LONGEST_LOW);
    assign wr_longest_high = reg_write_in && (reg_addr_in == `FRSB_OFS_LONGEST_HIGH);
    assign wr_shortest_low = reg_write_in && (reg_addr_in == `FRSB_OFS_SHORTEST_LOW);
    assign wr_shortest_high = reg_write_in && (reg_addr_in == `FRSB_OFS_SHORTEST_HIGH);
    assign wr_exposure_low = reg_write_in && (reg_addr_in == `FRSB_OFS_EXPOSURE_LOW);
    assign wr_exposure_high = reg_write_in && (reg_addr_in == `FRSB_OFS_EXPOSURE_HIGH);
    assign wr_laser_drive = reg_write_in && (reg_addr_in == `FRSB_OFS_LASER_DRIVE);

    // staging byte stores; none of these touch the active limits
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            longest_low_reg <= `FRSB_RST_LONGEST_LOW;
            longest_high_reg <= `FRSB_RST_LONGEST_HIGH;
            shortest_low_reg <= `FRSB_RST_SHORTEST_LOW;
            shortest_high_reg <= `FRSB_RST_SHORTEST_HIGH;
            exposure_low_reg <= `FRSB_RST_EXPOSURE_LOW;
            exposure_high_reg <= `FRSB_RST_EXPOSURE_HIGH;
            laser_drive_reg <= `FRSB_RST_LASER_DRIVE;
        end else begin
            if (wr_longest_low) longest_low_reg <= reg_wdata_in;
            if (wr_longest_high) longest_high_reg <= reg_wdata_in;
            if (wr_shortest_low) shortest_low_reg <= reg_wdata_in;
            if (wr_shortest_high) shortest_high_reg <= reg_wdata_in;
            if (wr_exposure_low) exposure_low_reg <= reg_wdata_in;
            if (wr_exposure_high) exposure_high_reg <= reg_wdata_in;
            if (wr_laser_drive) laser_drive_reg <= reg_wdata_in;
        end
    end

    // ==========================================================
    // commit sequencing
    frsb_commit_type commit_reg;
    frsb_commit_type commit_next;
    logic frame_start;
    logic apply_now;

    // count two frame starts after the commit write, then apply
    always_comb begin
        commit_next = commit_reg;
        case (commit_reg)
            COMMIT_IDLE: begin
                if (wr_longest_high) commit_next = COMMIT_WAIT_FIRST;
            end
            COMMIT_WAIT_FIRST: begin
                if (frame_start) commit_next = COMMIT_WAIT_SECOND;
            end
            COMMIT_WAIT_SECOND: begin
                if (frame_start) commit_next = COMMIT_IDLE;
            end
            default: begin
                commit_next = COMMIT_IDLE;
            end
        endcase
        if (wr_longest_high) commit_next = COMMIT_WAIT_FIRST;
    end

    assign apply_now = (commit_reg == COMMIT_WAIT_SECOND) && frame_start;
    // busy covers the whole wait between commit write and apply
    assign busy_out = (commit_reg != COMMIT_IDLE);

    // state register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            commit_reg <= COMMIT_IDLE;
        end else begin
            commit_reg <= commit_next;
        end
    end

    // pending capture on the upper longest write; a write while busy
    // recaptures, which the host is told not to do
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend_longest_reg <= {`FRSB_RST_LONGEST_HIGH, `FRSB_RST_LONGEST_LOW};
            pend_shortest_reg <= {`FRSB_RST_SHORTEST_HIGH, `FRSB_RST_SHORTEST_LOW};
            pend_exposure_reg <= {`FRSB_RST_EXPOSURE_HIGH, `FRSB_RST_EXPOSURE_LOW};
        end else if (wr_longest_high) begin
            pend_longest_reg <= {reg_wdata_in, longest_low_reg};
            pend_shortest_reg <= {shortest_high_reg, shortest_low_reg};
            pend_exposure_reg <= {exposure_high_reg, exposure_low_reg};
        end
    end

    // active limits change only at the apply point
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            act_longest_reg <= {`FRSB_RST_LONGEST_HIGH, `FRSB_RST_LONGEST_LOW};
            act_shortest_reg <= {`FRSB_RST_SHORTEST_HIGH, `FRSB_RST_SHORTEST_LOW};
            act_exposure_reg <= {`FRSB_RST_EXPOSURE_HIGH, `FRSB_RST_EXPOSURE_LOW};
        end else if (apply_now) begin
            act_longest_reg <= pend_longest_reg;
            act_shortest_reg <= pend_shortest_reg;
            act_exposure_reg <= pend_exposure_reg;
        end
    end

    // ==========================================================
    // frame period and exposure selection
    logic [15:0] auto_period_floor;
    logic [15:0] auto_period_clamped;
    logic [15:0] period_sel;
    logic [15:0] exposure_sel;

    // raise to the shortest bound first, then cap at the longest
    assign auto_period_floor = (auto_period_req_in < act_shortest_reg) ?
        act_shortest_reg : auto_period_req_in;
    assign auto_period_clamped = (auto_period_floor > act_longest_reg) ?
        act_longest_reg : auto_period_floor;
    assign period_sel = auto_frame_rate_en_in ? auto_period_clamped : act_longest_reg;
    // manual exposure runs at the ceiling value itself
    assign exposure_sel = !auto_exposure_en_in ? act_exposure_reg :
        ((auto_exposure_req_in > act_exposure_reg) ? act_exposure_reg : auto_exposure_req_in);

    // registered operating values
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            frame_period_out <= {`FRSB_RST_LONGEST_HIGH, `FRSB_RST_LONGEST_LOW};
            exposure_out <= {`FRSB_RST_EXPOSURE_HIGH, `FRSB_RST_EXPOSURE_LOW};
        end else begin
            frame_period_out <= period_sel;
            exposure_out <= exposure_sel;
        end
    end

    // frame timing counted in plain clock cycles
    frsb_frame_timer u_frame_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .period_in(frame_period_out),
        .frame_start_out(frame_start)
    );

    assign frame_start_out = frame_start;

    // ==========================================================
    // laser drive current selection
    logic complement_ok;

    // a mismatched complement protects the laser at the lowest current
    assign complement_ok = (laser_drive_complement_in == ~laser_drive_reg);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            laser_current_code_out <= `FRSB_LASER_CODE_LOWEST;
            laser_match_out <= 1'b0;
        end else begin
            laser_current_code_out <= complement_ok ?
                laser_drive_reg[`FRSB_LASER_CODE_MSB:0] : `FRSB_LASER_CODE_LOWEST;
            laser_match_out <= laser_drive_reg[`FRSB_LASER_MATCH_BIT];
        end
    end

    // ==========================================================
    // laser drive pin fault test
    localparam logic [10:0] FAULT_LAST = 11'(`FRSB_FAULT_PULSE_CYCLES - 1);
    frsb_fault_type fault_reg;
    frsb_fault_type fault_next;
    logic [10:0] fault_count_reg;
    logic [10:0] fault_count_next;
    logic fault_done;

    assign fault_done = (fault_count_reg == FAULT_LAST);

    // a new write restarts the test from its high pulse
    always_comb begin
        fault_next = fault_reg;
        fault_count_next = fault_done ? 11'h000 : fault_count_reg + 11'h001;
        case (fault_reg)
            FAULT_IDLE: begin
                fault_count_next = 11'h000;
            end
            FAULT_PULSE_HIGH: begin
                if (fault_done) fault_next = FAULT_PULSE_LOW;
            end
            FAULT_PULSE_LOW: begin
                if (fault_done) fault_next = FAULT_IDLE;
            end
            default: begin
                fault_next = FAULT_IDLE;
            end
        endcase
        if (wr_laser_drive) begin
            fault_next = FAULT_PULSE_HIGH;
            fault_count_next = 11'h000;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_reg <= FAULT_IDLE;
            fault_count_reg <= 11'h000;
        end else begin
            fault_reg <= fault_next;
            fault_count_reg <= fault_count_next;
        end
    end

    // pins registered; during the test the enable is held off
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            laser_drive_pin_out <= 1'b0;
            laser_enable_low_out <= 1'b1;
        end else begin
            case (fault_next)
                FAULT_PULSE_HIGH: begin
                    laser_drive_pin_out <= 1'b1;
                    laser_enable_low_out <= 1'b1;
                end
                FAULT_PULSE_LOW: begin
                    laser_drive_pin_out <= 1'b0;
                    laser_enable_low_out <= 1'b1;
                end
                default: begin
                    laser_drive_pin_out <= laser_drive_normal_in;
                    laser_enable_low_out <= laser_enable_low_normal_in;
                end
            endcase
        end
    end

    // ==========================================================
    // read path
    logic [7:0] firmware_rev;
    logic [7:0] rd_sel;

    assign firmware_rev = shadow_running_in ? shadow_revision_in : `FRSB_FIRMWARE_NONE;

    // staged bytes are read back, committed or not
    always_comb begin
        case (reg_addr_in)
            `FRSB_OFS_LONGEST_LOW: rd_sel = longest_low_reg;
            `FRSB_OFS_LONGEST_HIGH: rd_sel = longest_high_reg;
            `FRSB_OFS_SHORTEST_LOW: rd_sel = shortest_low_reg;
            `FRSB_OFS_SHORTEST_HIGH: rd_sel = shortest_high_reg;
            `FRSB_OFS_EXPOSURE_LOW: rd_sel = exposure_low_reg;
            `FRSB_OFS_EXPOSURE_HIGH: rd_sel = exposure_high_reg;
            `FRSB_OFS_FIRMWARE_REV: rd_sel = firmware_rev;
            `FRSB_OFS_LASER_DRIVE: rd_sel = laser_drive_reg;
            default: rd_sel = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_read_in;
            if (reg_read_in) reg_rdata_out <= rd_sel;
        end
    end

endmodule : frsb_bank

// file: verification/frsb_bank_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checks for the frame bound register bank
module frsb_bank_asserts
    import frsb_pkg::*;
(
    // clock, reset and register port
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // limits and operating values
    input wire logic auto_frame_rate_en_in,
    input wire logic auto_exposure_en_in,
    input wire logic busy_out,
    input wire logic [15:0] auto_exposure_req_in,
    input wire logic [15:0] frame_period_out,
    input wire logic [15:0] exposure_out,
    input wire logic frame_start_out,
    // firmware and laser
    input wire logic shadow_running_in,
    input wire logic [7:0] shadow_revision_in,
    input wire logic [7:0] laser_drive_complement_in,
    input wire logic [6:0] laser_current_code_out,
    input wire logic laser_match_out,
    input wire logic laser_drive_pin_out,
    input wire logic laser_enable_low_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ==========================================================
    // laser setting mirror and cycles since its write
    logic [11:0] fault_cnt_reg;
    logic [11:0] fault_cnt_next;
    logic [7:0] setting_reg;
    wire laser_wr = reg_write_in && reg_addr_in == 8'h2C;
    wire commit_wr = reg_write_in && reg_addr_in == 8'h1A;
    // counter parks at zero so a late rewrite restarts the test
    assign fault_cnt_next = laser_wr ? 12'h001 :
        (fault_cnt_reg != 12'h000 && fault_cnt_reg < 12'h961) ? fault_cnt_reg + 12'h001 : 12'h000;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_cnt_reg <= 12'h000;
            setting_reg <= 8'h7F;
        end else begin
            fault_cnt_reg <= fault_cnt_next;
            setting_reg <= laser_wr ? reg_wdata_in : setting_reg;
        end
    end
    // ==========================================================
    // assertions
    a_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
        else $error("read strobe without answer");
    a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_read_in))
        else $error("read answer without strobe");
    a_firmware_read: assert property (reg_read_in && reg_addr_in == 8'h1F |=>
        reg_rdata_out == ($past(shadow_running_in) ? $past(shadow_revision_in) : 8'h00))
        else $error("firmware revision read wrong");
    a_commit_busy: assert property (commit_wr |=> busy_out)
        else $error("busy not raised by commit");
    a_busy_drop: assert property ($fell(busy_out) |-> $past(frame_start_out))
        else $error("busy dropped off a frame boundary");
    a_period_held: assert property (busy_out && !auto_frame_rate_en_in && !$past(auto_frame_rate_en_in)
        |=> $stable(frame_period_out))
        else $error("manual period moved while staged");
    a_exposure_cap: assert property ($past(auto_exposure_en_in) && $past(nrst_in)
        |-> exposure_out <= $past(auto_exposure_req_in))
        else $error("auto exposure above request");
    a_fault_high: assert property (fault_cnt_reg inside {[12'h001:12'h4B0]}
        |-> laser_drive_pin_out && laser_enable_low_out)
        else $error("fault test high phase wrong");
    a_fault_low: assert property (fault_cnt_reg inside {[12'h4B1:12'h960]}
        |-> !laser_drive_pin_out && laser_enable_low_out)
        else $error("fault test low phase wrong");
    a_code_select: assert property (!laser_wr |=> laser_match_out == setting_reg[7] &&
        laser_current_code_out == (($past(laser_drive_complement_in) == ~setting_reg) ? setting_reg[6:0] : 7'h7F))
        else $error("laser code selection wrong");
    // main scenarios reached
    c_commit_done: cover property ($fell(busy_out));
    c_fault_done: cover property (fault_cnt_reg == 12'h960);
    c_read_data: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);
endmodule : frsb_bank_asserts

// file: verification/frsb_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side of the register port, changes lines on falling edges
module frsb_host_model
(
    // clock and answers
    input wire logic clk_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    input wire logic busy_in,
    // requests
    output logic [7:0] reg_addr_out,
    output logic reg_write_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_read_out
);
    initial {reg_addr_out, reg_write_out, reg_wdata_out, reg_read_out} = 18'h00000;
    // idle lines are inverted so a stale value is never mistaken for data
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_write_out = 1'b1;
        @(negedge clk_in);
        reg_write_out = 1'b0;
        reg_addr_out = ~addr;
        reg_wdata_out = ~data;
    endtask : wr
    // answer taken one cycle after the strobe, X if missing
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        reg_addr_out = addr;
        reg_read_out = 1'b1;
        @(negedge clk_in);
        data = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
        reg_read_out = 1'b0;
        reg_addr_out = ~addr;
    endtask : rd
    task automatic wr_pair(input logic [7:0] addr_low, input logic [15:0] value);
        wr(addr_low, value[7:0]);
        wr(addr_low + 8'h01, value[15:8]);
    endtask : wr_pair
    task automatic rd_pair(input logic [7:0] addr_low, output logic [15:0] value);
        rd(addr_low + 8'h01, value[15:8]);
        rd(addr_low, value[7:0]);
    endtask : rd_pair
    // poll busy instead of timing frames before touching limits again
    task automatic wait_idle(output logic ok);
        int n;
        n = 0;
        while (busy_in !== 1'b0 && n < 60000) begin
            @(negedge clk_in);
            n++;
        end
        ok = (busy_in === 1'b0);
    endtask : wait_idle
endmodule : frsb_host_model

// file: verification/tb.sv
`timescale 1ns/1ps
// ==========================================================
// testbench for the frame bound register bank
module tb;
    import frsb_pkg::*;
    logic clk_in, nrst_in, reg_write_in, reg_read_in, reg_rvalid_out, auto_frame_rate_en_in, auto_exposure_en_in;
    logic busy_out, frame_start_out, shadow_running_in, laser_drive_normal_in, laser_enable_low_normal_in;
    logic laser_match_out, laser_drive_pin_out, laser_enable_low_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, shadow_revision_in, laser_drive_complement_in;
    logic [15:0] auto_period_req_in, auto_exposure_req_in, frame_period_out, exposure_out;
    logic [6:0] laser_current_code_out;
    int error_cnt = 0, checks_done = 0, cycle_cnt = 0, seed = 32'hDE6F;
    logic [7:0] tbl_addr [9] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h2C, 8'h1F, 8'h40};
    logic [7:0] tbl_val [9] = '{8'h90, 8'h65, 8'h7E, 8'h0E, 8'h20, 8'h4E, 8'h7F, 8'h00, 8'h00};
    frsb_bank dut (.*);
    frsb_host_model host (.clk_in, .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out), .busy_in(busy_out),
        .reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in), .reg_wdata_out(reg_wdata_in),
        .reg_read_out(reg_read_in));
    // ==========================================================
    // clock, timeout, comparison and verdict
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // sized for two default frames of the first commit
    always @(posedge clk_in) begin
        cycle_cnt++;
        if (cycle_cnt == 99000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : clamp
    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic ok;
        logic [15:0] lng, sht, cel, v;
        int i, n;
        {nrst_in, auto_frame_rate_en_in, auto_exposure_en_in, shadow_running_in, laser_drive_normal_in} = 5'h00;
        {auto_period_req_in, auto_exposure_req_in, shadow_revision_in} = 40'h0;
        laser_drive_complement_in = 8'h80;
        laser_enable_low_normal_in = 1'b0;
        repeat (6) @(negedge clk_in);
        nrst_in = 1'b1;
        for (i = 0; i < 9; i++) begin
            host.rd(tbl_addr[i], d);
            check(16'(d), 16'(tbl_val[i]));
        end
        check(frame_period_out, 16'h6590);
        check(exposure_out, 16'h4E20);
        // staged limits keep longest >= shortest + ceiling
        cel = 16'h0100 + (16'($random(seed)) & 16'h00FF);
        sht = 16'h0E7E + (16'($random(seed)) & 16'h00FF);
        lng = sht + cel + (16'($random(seed)) & 16'h003F);
        host.wr(8'h19, lng[7:0]);
        host.wr_pair(8'h1B, sht);
        host.wr_pair(8'h1D, cel);
        repeat (3) @(negedge clk_in);
        check(frame_period_out, 16'h6590);
        check(exposure_out, 16'h4E20);
        host.rd_pair(8'h1B, v);
        check(v, sht);
        host.rd_pair(8'h1D, v);
        check(v, cel);
        host.wr(8'h1A, lng[15:8]);
        check(16'(busy_out), 16'h0001);
        host.wait_idle(ok);
        check(16'(ok), 16'h0001);
        repeat (2) @(negedge clk_in);
        check(frame_period_out, lng);
        check(exposure_out, cel);
        // a frame lasts the programmed count
        for (i = 0; i < 2; i++) begin
            @(negedge clk_in iff frame_start_out === 1'b1);
        end
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (frame_start_out !== 1'b1);
        check(16'(n), lng);
        // automatic control with corner requests first
        auto_frame_rate_en_in = 1'b1;
        auto_exposure_en_in = 1'b1;
        for (i = 0; i < 24; i++) begin
            auto_period_req_in = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed)) & 16'h1FFF;
            auto_exposure_req_in = (i == 0) ? 16'hFFFF : 16'($random(seed)) & 16'h03FF;
            @(negedge clk_in);
            check(frame_period_out, clamp(auto_period_req_in, sht, lng));
            check(exposure_out, clamp(auto_exposure_req_in, 16'h0000, cel));
        end
        auto_frame_rate_en_in = 1'b0;
        auto_exposure_en_in = 1'b0;
        @(negedge clk_in);
        check(frame_period_out, lng);
        check(exposure_out, cel);
        // firmware revision; a write is ignored
        shadow_running_in = 1'b1;
        shadow_revision_in = 8'($random(seed));
        host.wr(8'h1F, ~shadow_revision_in);
        host.rd(8'h1F, d);
        check(16'(d), 16'(shadow_revision_in));
        // laser setting and pin fault test
        v[7:0] = 8'($random(seed));
        laser_drive_complement_in = ~v[7:0];
        host.wr(8'h2C, v[7:0]);
        check({laser_enable_low_out, laser_drive_pin_out}, 16'h0003);
        repeat (1199) @(negedge clk_in);
        check({laser_enable_low_out, laser_drive_pin_out}, 16'h0003);
        laser_drive_normal_in = 1'b1;
        @(negedge clk_in);
        check({laser_enable_low_out, laser_drive_pin_out}, 16'h0002);
        repeat (1200) @(negedge clk_in);
        check({laser_enable_low_out, laser_drive_pin_out}, 16'h0001);
        check({laser_match_out, laser_current_code_out}, 16'(v[7:0]));
        laser_drive_complement_in = v[7:0];
        repeat (2) @(negedge clk_in);
        check(16'(laser_current_code_out), 16'h007F);
        host.rd(8'h2C, d);
        check(16'(d), 16'(v[7:0]));
        stop_test();
    end
endmodule : tb
bind frsb_bank frsb_bank_asserts chk (.*);
